// ### design/cfg_test_regs.sv
// Configuration and test register bank with APB slave, command, CRC and timer
//
// Behaviour
// - Read-write bits change only by host writes
// - Dynamic bits: host and engine both write
// - Command field returns to idle when done
// - Read-only bits ignore host writes entirely
// - Write-only registers always read zero
// - Undefined bits read zero, writes ignored
// - Sixteen-bit reload value over two bytes
// - Sixteen-bit live timer count over two bytes
// - Checksum result, high then low byte
// - Baud rate selector register for UART
// - Timer mode register steers the timer
// - Selftest control register drives selftest output
// - Internal bus monitor readable by host
// - I and Q converter value readable
// - Test select B controls PRBS generator
// - Command write starts, read shows running
`timescale 1ns/1ps
`default_nettype none

module cfg_test_regs (
	input wire logic i_clk_sys, // System clock, 100 MHz
	input wire logic i_rstn, // Async reset, active low
	input wire cfg_test_regs_pkg::apb_req_t i_apb, // APB request
	output cfg_test_regs_pkg::apb_rsp_t o_apb, // APB response
	input wire logic [7:0] i_iq_sample, // Live I and Q converter value
	output logic [7:0] o_baud_sel, // UART baud selector
	output logic [7:0] o_conductance, // Driver modulation conductance
	output logic [7:0] o_tx_phase, // Transmit bit phase
	output logic [7:0] o_rx_gain, // Receiver gain config
	output logic [7:0] o_test_pin_en, // Test pin output enables
	output logic [7:0] o_aux_ctrl, // Aux pin control
	output logic [7:0] o_dac1, // Test DAC one value
	output logic [7:0] o_dac2, // Test DAC two value
	output logic [7:0] o_selftest, // Selftest control
	output logic o_prbs_bit, // PRBS output bit
	output logic o_timer_expired // Timer underflow pulse
);

	// Whole state of the block
	typedef struct packed {
		cfg_test_regs_pkg::apb_rsp_t rsp;
		cfg_test_regs_pkg::cmd_t cmd;
		logic [3:0] cmd_cnt;
		logic [15:0] crc;
		logic crc_done;
		logic [7:0] feed;
		logic [7:0] baud;
		logic [7:0] gsn;
		logic [7:0] txph;
		logic [7:0] rfcfg;
		logic [7:0] tmode;
		logic [7:0] tpre;
		logic [15:0] treload;
		logic [15:0] tcount;
		logic [7:0] tpcnt;
		logic trun;
		logic texp;
		logic [7:0] tsel_a;
		logic [7:0] tsel_b;
		logic [7:0] tpin;
		logic [7:0] selftest;
		logic [7:0] aux;
		logic [7:0] dac1;
		logic [7:0] dac2;
		logic [8:0] prbs;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic setup;
	logic access;
	logic addr_ok;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic wr;
	logic [7:0] rbyte;
	logic [7:0] busmon;

	// One CRC step, message bit taken MSB first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? cfg_test_regs_pkg::CRC_POLY : 16'h0000);
	endfunction : crc_step

	// Decodes an index into mapped or not
	function automatic logic idx_mapped(input logic [7:0] i);
		idx_mapped = (i == cfg_test_regs_pkg::IDX_LAUNCHER)
			|| (i >= cfg_test_regs_pkg::IDX_MAP_FIRST && i <= cfg_test_regs_pkg::IDX_MAP_LAST)
			|| (i == cfg_test_regs_pkg::IDX_CRC_FEED)
			|| (i == cfg_test_regs_pkg::IDX_CRC_STATUS);
	endfunction : idx_mapped

	// APB decode
	assign setup = i_apb.psel && !i_apb.penable && !st_q.rsp.pready;
	assign access = i_apb.psel && i_apb.penable && st_q.rsp.pready;
	assign idx = i_apb.paddr[9:2];
	assign addr_ok = (i_apb.paddr[1:0] == 2'b00) && (i_apb.paddr[11:10] == 2'b00)
		&& idx_mapped(idx);
	assign wbyte = i_apb.pwdata[7:0];
	assign wr = access && i_apb.pwrite && !st_q.rsp.pslverr;

	// Test bus source select
	// monitor internal state
	always_comb begin
		case (st_q.tsel_a[1:0])
			2'b00: busmon = {st_q.trun, st_q.crc_done, 2'b00, st_q.cmd};
			2'b01: busmon = st_q.tcount[7:0];
			2'b10: busmon = st_q.crc[7:0];
			default: busmon = {st_q.texp, st_q.prbs[6:0]};
		endcase
	end

	// Read mux, byte per index
	always_comb begin
		case (idx)
			cfg_test_regs_pkg::IDX_LAUNCHER: rbyte = {4'h0, st_q.cmd};
			cfg_test_regs_pkg::IDX_BAUD: rbyte = st_q.baud;
			cfg_test_regs_pkg::IDX_CRC_MSB: rbyte = st_q.crc[15:8];
			cfg_test_regs_pkg::IDX_CRC_LSB: rbyte = st_q.crc[7:0];
			cfg_test_regs_pkg::IDX_GSN: rbyte = st_q.gsn;
			cfg_test_regs_pkg::IDX_TXPHASE: rbyte = st_q.txph;
			cfg_test_regs_pkg::IDX_RFCFG: rbyte = st_q.rfcfg;
			cfg_test_regs_pkg::IDX_TMODE: rbyte = st_q.tmode;
			cfg_test_regs_pkg::IDX_TPRESCALE: rbyte = st_q.tpre;
			cfg_test_regs_pkg::IDX_TRELOAD_HI: rbyte = st_q.treload[15:8];
			cfg_test_regs_pkg::IDX_TRELOAD_LO: rbyte = st_q.treload[7:0];
			cfg_test_regs_pkg::IDX_TCOUNT_HI: rbyte = st_q.tcount[15:8];
			cfg_test_regs_pkg::IDX_TCOUNT_LO: rbyte = st_q.tcount[7:0];
			cfg_test_regs_pkg::IDX_TESTSEL_A: rbyte = st_q.tsel_a;
			cfg_test_regs_pkg::IDX_TESTSEL_B: rbyte = st_q.tsel_b;
			cfg_test_regs_pkg::IDX_TESTPIN: rbyte = st_q.tpin;
			cfg_test_regs_pkg::IDX_BUSMON: rbyte = busmon;
			cfg_test_regs_pkg::IDX_SELFTEST: rbyte = st_q.selftest;
			cfg_test_regs_pkg::IDX_REVISION: rbyte = cfg_test_regs_pkg::REVISION_CODE;
			cfg_test_regs_pkg::IDX_AUX: rbyte = st_q.aux;
			cfg_test_regs_pkg::IDX_DAC1: rbyte = st_q.dac1;
			cfg_test_regs_pkg::IDX_DAC2: rbyte = st_q.dac2;
			cfg_test_regs_pkg::IDX_IQ: rbyte = i_iq_sample;
			cfg_test_regs_pkg::IDX_CRC_STATUS: rbyte = {7'h00, st_q.crc_done};
			default: rbyte = 8'h00;
		endcase
	end

	// Next state
	always_comb begin
		st_d = st_q;
		st_d.texp = 1'b0;

		// APB answer: pready in the cycle after setup
		st_d.rsp.pready = setup;
		if (setup) begin
			st_d.rsp.pslverr = !addr_ok;
			st_d.rsp.prdata = (addr_ok && !i_apb.pwrite) ? {24'h000000, rbyte} : 32'h00000000;
		end else if (access) begin
			st_d.rsp.pslverr = 1'b0;
			st_d.rsp.prdata = 32'h00000000;
		end

		// Command engine
		// engine overwrites dynamic field
		if (st_q.cmd != cfg_test_regs_pkg::CMD_IDLE) begin
			if (st_q.cmd == cfg_test_regs_pkg::CMD_CALC_CRC) begin
				st_d.crc = crc_step(st_q.crc, st_q.feed[st_q.cmd_cnt[2:0] - 3'd1]);
			end
			st_d.cmd_cnt = st_q.cmd_cnt - 4'd1;
			if (st_q.cmd_cnt == 4'd1) begin
				st_d.cmd = cfg_test_regs_pkg::CMD_IDLE;
				if (st_q.cmd == cfg_test_regs_pkg::CMD_CALC_CRC) begin
					st_d.crc_done = 1'b1;
				end
			end
		end

		// Timer, steps on prescaler underflow
		// mode bits steer timer
		if (st_q.trun) begin
			if (st_q.tpcnt == 8'h00) begin
				st_d.tpcnt = st_q.tpre;
				if (st_q.tcount == 16'h0000) begin
					st_d.texp = 1'b1;
					if (st_q.tmode[cfg_test_regs_pkg::TMODE_AUTO_BIT]) begin
						st_d.tcount = st_q.treload;
					end else begin
						st_d.trun = 1'b0;
					end
				end else begin
					st_d.tcount = st_q.tcount - 16'd1;
				end
			end else begin
				st_d.tpcnt = st_q.tpcnt - 8'd1;
			end
		end

		// PRBS9 generator
		// select B enables PRBS
		if (st_q.tsel_b[cfg_test_regs_pkg::PRBS_EN_BIT]) begin
			st_d.prbs = {st_q.prbs[7:0], st_q.prbs[8] ^ st_q.prbs[4]};
		end

		// Host writes at the access edge
		// only host path writes control bits
		if (wr) begin
			case (idx)
				cfg_test_regs_pkg::IDX_LAUNCHER: begin
					st_d.cmd = cfg_test_regs_pkg::cmd_t'(wbyte[cfg_test_regs_pkg::CMD_MSB:0]);
					st_d.cmd_cnt = cfg_test_regs_pkg::CMD_RUN_CYCLES;
					if (wbyte[3:0] == cfg_test_regs_pkg::CMD_CALC_CRC) begin
						st_d.crc = cfg_test_regs_pkg::CRC_PRESET;
						st_d.crc_done = 1'b0;
						st_d.cmd_cnt = cfg_test_regs_pkg::CRC_BITS;
					end
				end
				cfg_test_regs_pkg::IDX_BAUD: st_d.baud = wbyte;
				cfg_test_regs_pkg::IDX_GSN: st_d.gsn = wbyte;
				cfg_test_regs_pkg::IDX_TXPHASE: st_d.txph = wbyte;
				cfg_test_regs_pkg::IDX_RFCFG: st_d.rfcfg = wbyte;
				cfg_test_regs_pkg::IDX_TMODE: begin
					st_d.tmode = wbyte;
					st_d.trun = wbyte[cfg_test_regs_pkg::TMODE_EN_BIT];
					st_d.tcount = st_q.treload;
					st_d.tpcnt = st_q.tpre;
				end
				cfg_test_regs_pkg::IDX_TPRESCALE: st_d.tpre = wbyte;
				cfg_test_regs_pkg::IDX_TRELOAD_HI: st_d.treload[15:8] = wbyte;
				cfg_test_regs_pkg::IDX_TRELOAD_LO: st_d.treload[7:0] = wbyte;
				cfg_test_regs_pkg::IDX_TESTSEL_A: st_d.tsel_a = wbyte;
				cfg_test_regs_pkg::IDX_TESTSEL_B: begin
					st_d.tsel_b = wbyte;
					if (!st_q.tsel_b[cfg_test_regs_pkg::PRBS_EN_BIT]) begin
						st_d.prbs = cfg_test_regs_pkg::PRBS_SEED;
					end
				end
				cfg_test_regs_pkg::IDX_TESTPIN: st_d.tpin = wbyte;
				cfg_test_regs_pkg::IDX_SELFTEST: st_d.selftest = wbyte;
				cfg_test_regs_pkg::IDX_AUX: st_d.aux = wbyte;
				cfg_test_regs_pkg::IDX_DAC1: st_d.dac1 = wbyte;
				cfg_test_regs_pkg::IDX_DAC2: st_d.dac2 = wbyte;
				cfg_test_regs_pkg::IDX_CRC_FEED: st_d.feed = wbyte;
				default: st_d.feed = st_d.feed;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= '0;
			st_q.cmd <= cfg_test_regs_pkg::CMD_IDLE;
			st_q.crc <= cfg_test_regs_pkg::RST_WORD;
			st_q.baud <= cfg_test_regs_pkg::RST_BYTE;
			st_q.treload <= cfg_test_regs_pkg::RST_WORD;
			st_q.prbs <= cfg_test_regs_pkg::PRBS_SEED;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign o_apb = st_q.rsp;
	assign o_baud_sel = st_q.baud;
	assign o_conductance = st_q.gsn;
	assign o_tx_phase = st_q.txph;
	assign o_rx_gain = st_q.rfcfg;
	assign o_test_pin_en = st_q.tpin;
	assign o_aux_ctrl = st_q.aux;
	assign o_dac1 = st_q.dac1;
	assign o_dac2 = st_q.dac2;
	assign o_selftest = st_q.selftest;
	assign o_prbs_bit = st_q.prbs[8];
	assign o_timer_expired = st_q.texp;

	// Checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	logic rd_setup;
	assign rd_setup = setup && !i_apb.pwrite;

	chk_ready_after_setup: assert property (setup |=> o_apb.pready ##1 !o_apb.pready)
		else $error("pready not one cycle after setup");

	chk_wo_reads_zero: assert property (
		rd_setup && idx == cfg_test_regs_pkg::IDX_CRC_FEED |=> o_apb.prdata == 32'h00000000)
		else $error("write-only register read nonzero");

	chk_rw_stable: assert property (
		!(wr && idx == cfg_test_regs_pkg::IDX_BAUD) |=> st_q.baud == $past(st_q.baud))
		else $error("baud select changed without write");

	chk_cmd_autoclear: assert property (
		st_q.cmd != cfg_test_regs_pkg::CMD_IDLE && st_q.cmd_cnt == 4'd1 && !wr
		|=> st_q.cmd == cfg_test_regs_pkg::CMD_IDLE)
		else $error("command field not cleared at end");

	chk_crc_done_bound: assert property (
		$rose(st_q.cmd == cfg_test_regs_pkg::CMD_CALC_CRC)
		|-> ##[1:9] (st_q.crc_done || st_q.cmd != cfg_test_regs_pkg::CMD_CALC_CRC))
		else $error("checksum not done in time");

	chk_ro_ignores_write: assert property (
		wr && idx == cfg_test_regs_pkg::IDX_CRC_MSB && st_q.cmd == cfg_test_regs_pkg::CMD_IDLE
		|=> st_q.crc == $past(st_q.crc))
		else $error("host write altered checksum");

	chk_reload_write: assert property (
		wr && idx == cfg_test_regs_pkg::IDX_TRELOAD_LO |=> st_q.treload[7:0] == $past(wbyte))
		else $error("reload low byte not stored");

	chk_count_read: assert property (
		rd_setup && idx == cfg_test_regs_pkg::IDX_TCOUNT_HI
		|=> o_apb.prdata[7:0] == $past(st_q.tcount[15:8]))
		else $error("count high byte misread");

	chk_launch_read: assert property (
		rd_setup && idx == cfg_test_regs_pkg::IDX_LAUNCHER
		|=> o_apb.prdata[7:0] == {4'h0, $past(st_q.cmd)})
		else $error("launcher read wrong");

	chk_unmapped_err: assert property (setup && !addr_ok |=> o_apb.pslverr)
		else $error("unmapped access not flagged");

	chk_done_write_proof: assert property (
		wr && idx == cfg_test_regs_pkg::IDX_CRC_STATUS
		&& st_q.cmd == cfg_test_regs_pkg::CMD_IDLE
		|=> st_q.crc_done == $past(st_q.crc_done))
		else $error("host write altered checksum done flag");

	chk_baud_write: assert property (
		wr && idx == cfg_test_regs_pkg::IDX_BAUD |=> o_baud_sel == $past(wbyte))
		else $error("baud selector pin not updated");

	chk_busmon_count: assert property (
		rd_setup && idx == cfg_test_regs_pkg::IDX_BUSMON && st_q.tsel_a[1:0] == 2'h1
		|=> o_apb.prdata[7:0] == $past(st_q.tcount[7:0]))
		else $error("bus monitor count view wrong");

	chk_iq_live: assert property (
		rd_setup && idx == cfg_test_regs_pkg::IDX_IQ |=> o_apb.prdata[7:0] == $past(i_iq_sample))
		else $error("converter value misread");

	cov_crc_done: cover property ($rose(st_q.crc_done));
	cov_timer_expire: cover property (o_timer_expired);
	cov_slave_error: cover property (o_apb.pready && o_apb.pslverr);
	cov_prbs_run: cover property (st_q.tsel_b[cfg_test_regs_pkg::PRBS_EN_BIT] ##4 o_prbs_bit);
	cov_generic_cmd: cover property (st_q.cmd != cfg_test_regs_pkg::CMD_IDLE
		&& st_q.cmd != cfg_test_regs_pkg::CMD_CALC_CRC);

endmodule : cfg_test_regs

`default_nettype wire

// ### design/cfg_test_regs_pkg.sv
// Constants and carrier types for the configuration and test register bank
package cfg_test_regs_pkg;

	// Register indices; byte address on APB is four times the index
	localparam logic [7:0] IDX_LAUNCHER = 8'h01;
	localparam logic [7:0] IDX_BAUD = 8'h1F;
	localparam logic [7:0] IDX_CRC_MSB = 8'h21;
	localparam logic [7:0] IDX_CRC_LSB = 8'h22;
	localparam logic [7:0] IDX_GSN = 8'h23;
	localparam logic [7:0] IDX_TXPHASE = 8'h25;
	localparam logic [7:0] IDX_RFCFG = 8'h26;
	localparam logic [7:0] IDX_TMODE = 8'h2A;
	localparam logic [7:0] IDX_TPRESCALE = 8'h2B;
	localparam logic [7:0] IDX_TRELOAD_HI = 8'h2C;
	localparam logic [7:0] IDX_TRELOAD_LO = 8'h2D;
	localparam logic [7:0] IDX_TCOUNT_HI = 8'h2E;
	localparam logic [7:0] IDX_TCOUNT_LO = 8'h2F;
	localparam logic [7:0] IDX_TESTSEL_A = 8'h31;
	localparam logic [7:0] IDX_TESTSEL_B = 8'h32;
	localparam logic [7:0] IDX_TESTPIN = 8'h33;
	localparam logic [7:0] IDX_BUSMON = 8'h35;
	localparam logic [7:0] IDX_SELFTEST = 8'h36;
	localparam logic [7:0] IDX_REVISION = 8'h37;
	localparam logic [7:0] IDX_AUX = 8'h38;
	localparam logic [7:0] IDX_DAC1 = 8'h39;
	localparam logic [7:0] IDX_DAC2 = 8'h3A;
	localparam logic [7:0] IDX_IQ = 8'h3B;
	localparam logic [7:0] IDX_PTEST_FIRST = 8'h3C;
	localparam logic [7:0] IDX_PTEST_LAST = 8'h3F;
	localparam logic [7:0] IDX_CRC_FEED = 8'h40;
	localparam logic [7:0] IDX_CRC_STATUS = 8'h41;
	localparam logic [7:0] IDX_MAP_FIRST = 8'h1F;
	localparam logic [7:0] IDX_MAP_LAST = 8'h3F;

	// Field positions
	localparam int CMD_MSB = 3;
	localparam int TMODE_EN_BIT = 7;
	localparam int TMODE_AUTO_BIT = 4;
	localparam int PRBS_EN_BIT = 7;

	// Reset values, CRC preset and polynomial, PRBS seed
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] CRC_PRESET = 16'h6363;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [8:0] PRBS_SEED = 9'h1FF;

	// Arbitrary value, not a real part's code
	localparam logic [7:0] REVISION_CODE = 8'hA5;

	// Commands held in the launcher field
	typedef enum logic [3:0] {
		CMD_IDLE = 4'b0000,
		CMD_CALC_CRC = 4'b0011
	} cmd_t;

	// Timing: generic commands run a fixed time, CRC one bit per cycle
	localparam int CLK_MHZ = 100;
	localparam int CMD_RUN_NS = 100;
	localparam logic [3:0] CMD_RUN_CYCLES = 4'((CMD_RUN_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] CRC_BITS = 4'h8;

	// APB carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage : cfg_test_regs_pkg

// ### tb/tb.sv
// Self-checking bench for the configuration and test register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic i_clk_sys;
	logic i_rstn;
	cfg_test_regs_pkg::apb_req_t i_apb;
	cfg_test_regs_pkg::apb_rsp_t o_apb;
	logic [7:0] i_iq_sample;
	logic [7:0] o_baud_sel, o_conductance, o_tx_phase, o_rx_gain, o_test_pin_en;
	logic [7:0] o_aux_ctrl, o_dac1, o_dac2, o_selftest;
	logic o_prbs_bit;
	logic o_timer_expired;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int pulses = 0;
	logic [31:0] rd;
	logic err;
	logic [15:0] crc;
	logic [39:0] bits;
	logic [7:0] rw_idx [13];
	logic [7:0] ports [9];
	logic [7:0] rsvd_idx [7];

	cfg_test_regs cfg_test_regs_i (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_apb(i_apb),
		.o_apb(o_apb),
		.i_iq_sample(i_iq_sample),
		.o_baud_sel(o_baud_sel),
		.o_conductance(o_conductance),
		.o_tx_phase(o_tx_phase),
		.o_rx_gain(o_rx_gain),
		.o_test_pin_en(o_test_pin_en),
		.o_aux_ctrl(o_aux_ctrl),
		.o_dac1(o_dac1),
		.o_dac2(o_dac2),
		.o_selftest(o_selftest),
		.o_prbs_bit(o_prbs_bit),
		.o_timer_expired(o_timer_expired)
	);

	// Free-running 100 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// Hang guard and timer pulse counter
	always @(posedge i_clk_sys) begin
		cycles++;
		if (o_timer_expired === 1'b1) pulses++;
		if (cycles == 6000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// One APB transfer; request held until pready is seen at an edge
	task automatic xfer(input logic is_wr, input logic [11:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: is_wr, paddr: addr, pwdata: wd};
		@(posedge i_clk_sys);
		i_apb.penable <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_apb.pready !== 1'b1 && n < 20);
		rd = o_apb.prdata;
		err = o_apb.pslverr;
		check("pready", 32'h1, {31'h0, o_apb.pready});
		i_apb.psel <= 1'b0;
		i_apb.penable <= 1'b0;
		@(posedge i_clk_sys);
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, {2'b00, idx, 2'b00}, {24'hFFFFFF, d});
		check("wr_err", 32'h0, {31'h0, err});
	endtask : wr

	task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0);
		check(name, 32'h0, {31'h0, err});
		check(name, {24'h0, exp}, rd);
	endtask : rdc

	// Collect 40 PRBS output bits
	task automatic grab_prbs();
		for (int i = 0; i < 40; i++) begin
			@(posedge i_clk_sys);
			bits[i] = o_prbs_bit;
		end
	endtask : grab_prbs

	function automatic logic [7:0] val_of(input logic [7:0] idx);
		return (idx == cfg_test_regs_pkg::IDX_GSN) ? 8'h3F : idx ^ 8'h5A;
	endfunction : val_of

	// Checksum of one byte, MSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ cfg_test_regs_pkg::CRC_POLY) : c << 1;
		return c;
	endfunction : crc_byte

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		i_apb = '0;
		i_rstn = 1'b0;
		i_iq_sample = 8'h5A;
		rw_idx = '{cfg_test_regs_pkg::IDX_BAUD, cfg_test_regs_pkg::IDX_GSN,
			cfg_test_regs_pkg::IDX_TXPHASE, cfg_test_regs_pkg::IDX_RFCFG,
			cfg_test_regs_pkg::IDX_TESTPIN, cfg_test_regs_pkg::IDX_SELFTEST,
			cfg_test_regs_pkg::IDX_AUX, cfg_test_regs_pkg::IDX_DAC1, cfg_test_regs_pkg::IDX_DAC2,
			cfg_test_regs_pkg::IDX_TPRESCALE, cfg_test_regs_pkg::IDX_TRELOAD_HI,
			cfg_test_regs_pkg::IDX_TRELOAD_LO, cfg_test_regs_pkg::IDX_TESTSEL_A};
		rsvd_idx = '{8'h20, 8'h24, 8'h27, 8'h28, 8'h29, 8'h30, 8'h34};
		repeat (20) @(posedge i_clk_sys);
		check("rst_a", 32'h0, {o_baud_sel, o_conductance, o_tx_phase, o_rx_gain});
		check("rst_b", 32'h0, {o_test_pin_en, o_aux_ctrl, o_dac1, o_dac2});
		check("rst_c", 32'h2, {22'h0, o_selftest, o_prbs_bit, o_timer_expired});
		i_rstn <= 1'b1;
		@(posedge i_clk_sys);
		rdc("rev", cfg_test_regs_pkg::IDX_REVISION, cfg_test_regs_pkg::REVISION_CODE);
		// Fill thirteen read-write bytes first, then read them back and check nine pins
		for (int i = 0; i < 13; i++) wr(rw_idx[i], val_of(rw_idx[i]));
		for (int i = 0; i < 13; i++) rdc("rw", rw_idx[i], val_of(rw_idx[i]));
		ports = '{o_baud_sel, o_conductance, o_tx_phase, o_rx_gain, o_test_pin_en, o_selftest,
			o_aux_ctrl, o_dac1, o_dac2};
		for (int i = 0; i < 9; i++) check("pin", {24'h0, val_of(rw_idx[i])}, {24'h0, ports[i]});
		wr(cfg_test_regs_pkg::IDX_REVISION, 8'hFF);
		rdc("rev_wr", cfg_test_regs_pkg::IDX_REVISION, cfg_test_regs_pkg::REVISION_CODE);
		wr(cfg_test_regs_pkg::IDX_CRC_STATUS, 8'h01);
		rdc("done_wr", cfg_test_regs_pkg::IDX_CRC_STATUS, 8'h00);
		wr(cfg_test_regs_pkg::IDX_IQ, 8'h00);
		rdc("iq_a", cfg_test_regs_pkg::IDX_IQ, 8'h5A);
		i_iq_sample <= 8'hC3;
		rdc("iq_b", cfg_test_regs_pkg::IDX_IQ, 8'hC3);
		// reserved reads held only to the bank's zero choice
		foreach (rsvd_idx[i]) rdc("rsvd", rsvd_idx[i], 8'h00);
		// production test area is read, never written
		rdc("ptest", cfg_test_regs_pkg::IDX_PTEST_FIRST, 8'h00);
		// Refused accesses leave the target untouched
		xfer(1'b0, 12'h000, 32'h0);
		check("unmapped", 32'h1, {31'h0, err});
		xfer(1'b1, {2'b00, cfg_test_regs_pkg::IDX_BAUD, 2'b01}, 32'h77);
		check("misalign", 32'h1, {31'h0, err});
		rdc("baud_kept", cfg_test_regs_pkg::IDX_BAUD, val_of(cfg_test_regs_pkg::IDX_BAUD));
		// Short command, then a checksum run
		wr(cfg_test_regs_pkg::IDX_LAUNCHER, 8'hF7);
		rdc("cmd_gen", cfg_test_regs_pkg::IDX_LAUNCHER, 8'h07);
		repeat (cfg_test_regs_pkg::CMD_RUN_CYCLES) @(posedge i_clk_sys);
		rdc("cmd_end", cfg_test_regs_pkg::IDX_LAUNCHER, 8'h00);
		wr(cfg_test_regs_pkg::IDX_CRC_FEED, 8'h31);
		rdc("feed", cfg_test_regs_pkg::IDX_CRC_FEED, 8'h00);
		wr(cfg_test_regs_pkg::IDX_LAUNCHER, 8'h03);
		rdc("cmd_run", cfg_test_regs_pkg::IDX_LAUNCHER, 8'h03);
		repeat (10) @(posedge i_clk_sys);
		rdc("cmd_done", cfg_test_regs_pkg::IDX_LAUNCHER, 8'h00);
		rdc("crc_flag", cfg_test_regs_pkg::IDX_CRC_STATUS, 8'h01);
		crc = crc_byte(cfg_test_regs_pkg::CRC_PRESET, 8'h31);
		rdc("crc_hi", cfg_test_regs_pkg::IDX_CRC_MSB, crc[15:8]);
		rdc("crc_lo", cfg_test_regs_pkg::IDX_CRC_LSB, crc[7:0]);
		wr(cfg_test_regs_pkg::IDX_CRC_MSB, 8'h00);
		rdc("crc_kept", cfg_test_regs_pkg::IDX_CRC_MSB, crc[15:8]);
		wr(cfg_test_regs_pkg::IDX_TESTSEL_A, 8'h00);
		rdc("mon_st", cfg_test_regs_pkg::IDX_BUSMON, 8'h40);
		wr(cfg_test_regs_pkg::IDX_TESTSEL_A, 8'h02);
		rdc("mon_crc", cfg_test_regs_pkg::IDX_BUSMON, crc[7:0]);
		// Timer: slow count is read live, then one-shot and auto-reload underflows
		wr(cfg_test_regs_pkg::IDX_TRELOAD_HI, 8'h12);
		wr(cfg_test_regs_pkg::IDX_TRELOAD_LO, 8'h34);
		wr(cfg_test_regs_pkg::IDX_TPRESCALE, 8'hFF);
		wr(cfg_test_regs_pkg::IDX_TMODE, 8'h80);
		rdc("cnt_hi", cfg_test_regs_pkg::IDX_TCOUNT_HI, 8'h12);
		rdc("cnt_lo", cfg_test_regs_pkg::IDX_TCOUNT_LO, 8'h34);
		rdc("tmode", cfg_test_regs_pkg::IDX_TMODE, 8'h80);
		wr(cfg_test_regs_pkg::IDX_TMODE, 8'h00);
		wr(cfg_test_regs_pkg::IDX_TRELOAD_HI, 8'h00);
		wr(cfg_test_regs_pkg::IDX_TRELOAD_LO, 8'h02);
		wr(cfg_test_regs_pkg::IDX_TPRESCALE, 8'h01);
		pulses = 0;
		wr(cfg_test_regs_pkg::IDX_TMODE, 8'h80);
		repeat (60) @(posedge i_clk_sys);
		check("one_shot", 32'h1, pulses);
		pulses = 0;
		wr(cfg_test_regs_pkg::IDX_TMODE, 8'h90);
		repeat (60) @(posedge i_clk_sys);
		wr(cfg_test_regs_pkg::IDX_TMODE, 8'h00);
		check("auto", 32'h1, {31'h0, pulses > 5});
		// Stopping the timer reloads the count, seen through the monitor
		wr(cfg_test_regs_pkg::IDX_TESTSEL_A, 8'h01);
		rdc("mon_cnt", cfg_test_regs_pkg::IDX_BUSMON, 8'h02);
		// Sequence generator runs only while enabled
		wr(cfg_test_regs_pkg::IDX_TESTSEL_B, 8'h80);
		grab_prbs();
		check("prbs_run", 32'h1, {31'h0, (|bits) & ~(&bits)});
		wr(cfg_test_regs_pkg::IDX_TESTSEL_B, 8'h00);
		grab_prbs();
		check("prbs_hold", 32'h1, {31'h0, (&bits) | ~(|bits)});
		complete_run();
	end
endmodule : tb

`default_nettype wire
